// ==== src/prescale_if.sv ====
`timescale 1ns/100ps
interface prescale_if;
    logic run;
    logic [3:0] tick;
    modport gen (input run, output tick);
    modport taker (input tick, output run);
endinterface

// ==== src/prescaler.sv ====
`timescale 1ns/100ps
module prescaler
    import timer_pair_pkg::*;
#(
    parameter int WIDTH = PRESCALE_W
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    prescale_if.gen tap_if
);

    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    logic [3:0] tick_q;
    logic [3:0] tick_d;

    always_comb begin
        cnt_d = tap_if.run ? cnt_q + 1'b1 : '0;
    end

    // one-cycle tick each time the low bits of the count roll over
    for (genvar i = 0; i < 4; i++) begin : g_tap
        assign tick_d[i] = tap_if.run && (&cnt_q[TAP_LOG[i]-1:0]); // RULE_08
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
            tick_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tap_if.tick = tick_q;

endmodule // prescaler

// ==== src/timer_pair_pkg.sv ====
package timer_pair_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [2:0] OFS_RUN = 3'h0;
    localparam logic [2:0] OFS_MODE = 3'h1;
    localparam logic [2:0] OFS_FFCR = 3'h2;
    localparam logic [2:0] OFS_LCMP = 3'h3;
    localparam logic [2:0] OFS_UCMP = 3'h4;
    localparam logic [2:0] OFS_LCNT = 3'h5;
    localparam logic [2:0] OFS_UCNT = 3'h6;

    // run register fields
    localparam int RUN_LOWER_BIT = 0;
    localparam int RUN_UPPER_BIT = 1;
    localparam int RUN_PRESCALE_BIT = 2;
    localparam int RUN_DBUF_BIT = 7;

    // mode register fields
    localparam int MODE_LCLK_LSB = 0;
    localparam int MODE_UCLK_LSB = 2;
    localparam int MODE_CYCLE_LSB = 4;
    localparam int MODE_PAIR_LSB = 6;

    // flip-flop control fields
    localparam int FF_SRC_BIT = 0;
    localparam int FF_INV_BIT = 1;
    localparam int FF_CTRL_LSB = 2;
    localparam logic [1:0] FF_CTRL_INVERT = 2'h0;
    localparam logic [1:0] FF_CTRL_SET = 2'h1;
    localparam logic [1:0] FF_CTRL_CLEAR = 2'h2;
    localparam logic [1:0] FF_CTRL_KEEP = 2'h3;

    // pwm cycle field codes
    localparam logic [1:0] CYCLE_2E6 = 2'h1;
    localparam logic [1:0] CYCLE_2E7 = 2'h2;
    localparam logic [7:0] LAST_2E6 = 8'h3F;
    localparam logic [7:0] LAST_2E7 = 8'h7F;
    localparam logic [7:0] LAST_2E8 = 8'hFF;

    // reset values
    localparam logic [7:0] RUN_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [1:0] FFCR_RESET = 2'h0;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic TFF_RESET = 1'b0;

    // prescaler taps, in input clock cycles
    localparam int TAP_FINE_DIV = 8;
    localparam int TAP_MEDIUM_DIV = 32;
    localparam int TAP_COARSE_DIV = 128;
    localparam int TAP_SLOWEST_DIV = 2048;
    localparam int TAP_FINE = 0;
    localparam int TAP_MEDIUM = 1;
    localparam int TAP_COARSE = 2;
    localparam int TAP_SLOWEST = 3;
    localparam int TAP_LOG [4] = '{$clog2(TAP_FINE_DIV), $clog2(TAP_MEDIUM_DIV),
                                   $clog2(TAP_COARSE_DIV), $clog2(TAP_SLOWEST_DIV)};
    localparam int PRESCALE_W = $clog2(TAP_SLOWEST_DIV);

    // pwm period figures at the reference input clock
    localparam int REF_FC_PERIOD_NS = 50;
    localparam int PWM_MIN_PERIOD_NS = 25600;
    localparam int PWM_MAX_PERIOD_NS = 1638400;
    localparam int PWM_MIN_CYCLES = PWM_MIN_PERIOD_NS / REF_FC_PERIOD_NS;
    localparam int PWM_MAX_CYCLES = PWM_MAX_PERIOD_NS / REF_FC_PERIOD_NS;

    typedef enum logic [1:0] {
        PAIR_TWO_8BIT,
        PAIR_CASCADE_16,
        PAIR_PPG_8,
        PAIR_PWM_8
    } pair_mode_e;

endpackage

// ==== src/timer_pair_pwm.sv ====
// Operation
// RULE_01: pwm runs only on the lower timer, while the upper timer stays a plain 8-bit timer.
// RULE_02: in pwm the output flip-flop toggles on compare match and on the 2^n overflow.
// RULE_03: in pwm the lower counter clears to zero at each 2^n overflow.
// RULE_04: software keeps the lower compare value nonzero and below the 2^n overflow value.
// RULE_05: with the double buffer on, the buffered compare moves in at each 2^n overflow.
// RULE_06: the pair mode field picks two timers, 16-bit cascade, ppg, or pwm plus timer.
// RULE_07: the cycle field codes 01, 10, 11 select 2^6, 2^7 and 2^8 counts.
// RULE_08: the pwm period is 2^n times the chosen prescaler tap period.
// RULE_09: writing 10 to the control pair clears the flip-flop; the invert bit allows toggles.
// RULE_10: clearing the lower run bit stops the lower counter and clears it.
// RULE_11: software configures everything first, then sets double buffer and run together.
// RULE_12: lower clock codes 00..11 pick the external input, then the three lower taps.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module timer_pair_pwm
    import timer_pair_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic ext_clock_in,
    output logic [DATA_W-1:0] rdata_out,
    output logic timer_output_pin_out
);

    function automatic logic pick_source(input logic [1:0] sel, input logic s0,
                                         input logic s1, input logic s2, input logic s3);
        logic r;
        unique case (sel)
            2'h0: r = s0;
            2'h1: r = s1;
            2'h2: r = s2;
            2'h3: r = s3;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] overflow_last(input logic [1:0] cycle);
        logic [7:0] r;
        unique case (cycle)
            CYCLE_2E6: r = LAST_2E6;
            CYCLE_2E7: r = LAST_2E7;
            default: r = LAST_2E8;
        endcase
        return r;
    endfunction

    prescale_if tap_bus ();

    prescaler #(
        .WIDTH(PRESCALE_W)
    ) u_prescaler (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .tap_if(tap_bus.gen)
    );

    logic [7:0] run_q;
    logic [7:0] run_d;
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [1:0] ffcr_q;
    logic [1:0] ffcr_d;
    logic [7:0] lcmp_q;
    logic [7:0] lcmp_d;
    logic [7:0] lbuf_q;
    logic [7:0] lbuf_d;
    logic [7:0] ucmp_q;
    logic [7:0] ucmp_d;
    logic [7:0] lcnt_q;
    logic [7:0] lcnt_d;
    logic [7:0] ucnt_q;
    logic [7:0] ucnt_d;
    logic tff_q;
    logic tff_d;
    logic ext_prev_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    pair_mode_e pair_mode;
    logic [7:0] pwm_last;
    logic [7:0] lcnt_inc;
    logic [7:0] ucnt_inc;
    logic ext_rise;
    logic lower_tick;
    logic upper_tick;
    logic lower_match;
    logic upper_match;
    logic lower_wrap;
    logic match16;
    logic ppg_end;
    logic pwm_ovf;
    logic toggle_event;
    logic dbuf_load;
    logic ff_write;
    logic dbuf_en;

    assign tap_bus.run = run_q[RUN_PRESCALE_BIT];
    assign pair_mode = pair_mode_e'(mode_q[MODE_PAIR_LSB +: 2]);
    assign dbuf_en = run_q[RUN_DBUF_BIT];
    assign ff_write = wr_in && (addr_in == OFS_FFCR);

    // event decode
    always_comb begin
        ext_rise = ext_clock_in && !ext_prev_q;
        pwm_last = overflow_last(mode_q[MODE_CYCLE_LSB +: 2]); // RULE_07
        lcnt_inc = lcnt_q + 8'h01;
        ucnt_inc = ucnt_q + 8'h01;
        lower_tick = run_q[RUN_LOWER_BIT] && pick_source(mode_q[MODE_LCLK_LSB +: 2], ext_rise,
            tap_bus.tick[TAP_FINE], tap_bus.tick[TAP_MEDIUM], tap_bus.tick[TAP_COARSE]); // RULE_12
        lower_match = lower_tick && (lcnt_inc == lcmp_q);
        lower_wrap = lower_tick && (lcnt_q == LAST_2E8);
        match16 = lower_tick && ({ucnt_q, lcnt_inc} == {ucmp_q, lcmp_q}) && (lcnt_q != LAST_2E8);
        ppg_end = lower_tick && (lcnt_inc == ucmp_q);
        // nonzero compare value below the overflow keeps match and overflow apart
        pwm_ovf = (pair_mode == PAIR_PWM_8) && lower_tick && (lcnt_q == pwm_last); // RULE_04
        upper_tick = 1'b0;
        toggle_event = 1'b0;
        dbuf_load = 1'b0;
        unique case (pair_mode) // RULE_06
            PAIR_TWO_8BIT: begin
                upper_tick = pick_source(mode_q[MODE_UCLK_LSB +: 2], lower_match,
                    tap_bus.tick[TAP_FINE], tap_bus.tick[TAP_COARSE], tap_bus.tick[TAP_SLOWEST]);
            end
            PAIR_CASCADE_16: begin
                upper_tick = lower_wrap;
                toggle_event = match16;
            end
            PAIR_PPG_8: begin
                toggle_event = lower_match || ppg_end;
                dbuf_load = ppg_end;
            end
            PAIR_PWM_8: begin
                upper_tick = pick_source(mode_q[MODE_UCLK_LSB +: 2], 1'b0,
                    tap_bus.tick[TAP_FINE], tap_bus.tick[TAP_COARSE],
                    tap_bus.tick[TAP_SLOWEST]); // RULE_01
                toggle_event = lower_match || pwm_ovf; // RULE_02
                dbuf_load = pwm_ovf; // RULE_05
            end
        endcase
        upper_tick = upper_tick && run_q[RUN_UPPER_BIT];
        upper_match = upper_tick && (ucnt_inc == ucmp_q);
        if (pair_mode == PAIR_TWO_8BIT) begin
            toggle_event = ffcr_q[FF_SRC_BIT] ? upper_match : lower_match;
        end
    end

    // counters
    always_comb begin
        lcnt_d = lcnt_q;
        ucnt_d = ucnt_q;
        if (!run_q[RUN_LOWER_BIT]) begin
            lcnt_d = 8'h00; // RULE_10
        end else if (lower_tick) begin
            unique case (pair_mode)
                PAIR_TWO_8BIT: lcnt_d = lower_match ? 8'h00 : lcnt_inc;
                PAIR_CASCADE_16: lcnt_d = match16 ? 8'h00 : lcnt_inc;
                PAIR_PPG_8: lcnt_d = ppg_end ? 8'h00 : lcnt_inc;
                PAIR_PWM_8: lcnt_d = pwm_ovf ? 8'h00 : lcnt_inc; // RULE_03
            endcase
        end
        if (!run_q[RUN_UPPER_BIT]) begin
            ucnt_d = 8'h00;
        end else if (pair_mode == PAIR_CASCADE_16) begin
            if (match16) begin
                ucnt_d = 8'h00;
            end else if (upper_tick) begin
                ucnt_d = ucnt_inc;
            end
        end else if (upper_tick) begin
            ucnt_d = upper_match ? 8'h00 : ucnt_inc;
        end
    end

    // registers, flip-flop and read port
    always_comb begin
        run_d = run_q;
        mode_d = mode_q;
        ffcr_d = ffcr_q;
        lcmp_d = lcmp_q;
        lbuf_d = lbuf_q;
        ucmp_d = ucmp_q;
        tff_d = tff_q;
        rdata_d = 8'h00;
        if (toggle_event && ffcr_q[FF_INV_BIT]) begin
            tff_d = !tff_q; // RULE_09
        end
        if (dbuf_load && dbuf_en) begin
            lcmp_d = lbuf_q; // RULE_05
        end
        if (wr_in) begin
            unique case (addr_in)
                OFS_RUN: run_d = wdata_in;
                OFS_MODE: mode_d = wdata_in;
                OFS_FFCR: begin
                    ffcr_d = wdata_in[1:0];
                    unique case (wdata_in[FF_CTRL_LSB +: 2])
                        FF_CTRL_INVERT: tff_d = !tff_q;
                        FF_CTRL_SET: tff_d = 1'b1;
                        FF_CTRL_CLEAR: tff_d = 1'b0; // RULE_09
                        FF_CTRL_KEEP: tff_d = tff_d;
                    endcase
                end
                OFS_LCMP: begin
                    lbuf_d = wdata_in;
                    if (!dbuf_en) begin
                        lcmp_d = wdata_in;
                    end
                end
                OFS_UCMP: ucmp_d = wdata_in;
                default: ;
            endcase
        end
        if (rd_in) begin
            unique case (addr_in)
                OFS_RUN: rdata_d = run_q;
                OFS_MODE: rdata_d = mode_q;
                OFS_FFCR: rdata_d = {4'h0, FF_CTRL_KEEP, ffcr_q};
                OFS_LCMP: rdata_d = lcmp_q;
                OFS_UCMP: rdata_d = ucmp_q;
                OFS_LCNT: rdata_d = lcnt_q;
                OFS_UCNT: rdata_d = ucnt_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            run_q <= RUN_RESET;
            mode_q <= MODE_RESET;
            ffcr_q <= FFCR_RESET;
            lcmp_q <= CMP_RESET;
            lbuf_q <= CMP_RESET;
            ucmp_q <= CMP_RESET;
            lcnt_q <= 8'h00;
            ucnt_q <= 8'h00;
            tff_q <= TFF_RESET;
            ext_prev_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            run_q <= run_d;
            mode_q <= mode_d;
            ffcr_q <= ffcr_d;
            lcmp_q <= lcmp_d;
            lbuf_q <= lbuf_d;
            ucmp_q <= ucmp_d;
            lcnt_q <= lcnt_d;
            ucnt_q <= ucnt_d;
            tff_q <= tff_d;
            ext_prev_q <= ext_clock_in;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out = rdata_q;
    assign timer_output_pin_out = tff_q;

    // period watch: cycles since the last overflow with configuration untouched
    logic [15:0] per_cnt_q;
    logic per_valid_q;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            per_cnt_q <= 16'h0000;
            per_valid_q <= 1'b0;
        end else begin
            per_cnt_q <= pwm_ovf ? 16'h0000 : per_cnt_q + 16'h0001;
            per_valid_q <= wr_in ? 1'b0 : (pwm_ovf || per_valid_q);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_fine_2e6;
        pwm_ovf && per_valid_q && (mode_q[MODE_CYCLE_LSB +: 2] == CYCLE_2E6)
            && (mode_q[MODE_LCLK_LSB +: 2] == 2'h1) && !wr_in;
    endsequence

    sequence s_ff_clear_write;
        ff_write && (wdata_in[FF_CTRL_LSB +: 2] == FF_CTRL_CLEAR);
    endsequence

    chk_pwm_period_min: assert property ( // RULE_08
        s_fine_2e6 |-> (per_cnt_q == 16'(PWM_MIN_CYCLES - 1)))
        else $error("pwm period on finest tap at 2^6 is wrong");

    chk_pwm_ovf_clear: assert property ( // RULE_03
        pwm_ovf && !wr_in |=> (lcnt_q == 8'h00))
        else $error("lower counter not cleared at pwm overflow");

    chk_pwm_toggle: assert property ( // RULE_02
        (pair_mode == PAIR_PWM_8) && ffcr_q[FF_INV_BIT] && (lower_match || pwm_ovf)
            && !ff_write |=> (tff_q != $past(tff_q)))
        else $error("flip-flop missed a pwm toggle");

    chk_pwm_dbuf_load: assert property ( // RULE_05
        pwm_ovf && dbuf_en && !(wr_in && (addr_in == OFS_LCMP)) |=> (lcmp_q == $past(lbuf_q)))
        else $error("buffered compare not loaded at overflow");

    chk_lower_stop_clear: assert property ( // RULE_10
        !run_q[RUN_LOWER_BIT] |=> (lcnt_q == 8'h00))
        else $error("stopped lower counter not zero");

    chk_ff_clear_write: assert property ( // RULE_09
        s_ff_clear_write |=> !tff_q ##1 (tff_q == 1'b0 || $past(toggle_event) || $past(ff_write)))
        else $error("flip-flop not cleared by control write");

    chk_pwm_count_range: assert property ( // RULE_07
        (pair_mode == PAIR_PWM_8) && $stable(mode_q) && run_q[RUN_LOWER_BIT]
            && ($past(lcnt_q) <= pwm_last) |-> (lcnt_q <= pwm_last))
        else $error("lower counter passed the selected overflow");

    chk_upper_in_pwm: assert property ( // RULE_01
        (pair_mode == PAIR_PWM_8) && upper_match |=> (ucnt_q == 8'h00) && (lcnt_q != 8'hFF
            || $past(run_q[RUN_LOWER_BIT])))
        else $error("upper timer did not run independently in pwm");

    chk_cascade_carry: assert property ( // RULE_06
        (pair_mode == PAIR_CASCADE_16) && run_q[RUN_UPPER_BIT] && lower_wrap && !wr_in
            |=> (ucnt_q == 8'($past(ucnt_q) + 8'h01)) && (lcnt_q == 8'h00))
        else $error("cascade did not carry into the upper counter");

endmodule // timer_pair_pwm

// ==== verification/tb_timer_pair_pwm.sv ====
`timescale 1ns/100ps
module tb_timer_pair_pwm import timer_pair_pkg::*; ();
    localparam int LIMIT = 95000;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [ADDR_W-1:0] addr_in = '0;
    logic [DATA_W-1:0] wdata_in = '0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic ext_clock_in = 1'b0;
    logic [DATA_W-1:0] rdata_out;
    logic timer_output_pin_out;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] lfsr_q = 32'hC1FB46B6;
    logic [7:0] exp_q[$];
    logic rd_pend = 1'b0;
    logic ext_en = 1'b0;
    logic [1:0] ext_cnt = 2'h0;

    timer_pair_pwm timer_pair_pwm_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .ext_clock_in(ext_clock_in),
        .rdata_out(rdata_out), .timer_output_pin_out(timer_output_pin_out)
    );

    initial begin
        forever #2.5 clk_in = ~clk_in;
    end

    function automatic int rnd(input int range);
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return int'(lfsr_q % range);
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // read results: oldest note against data in the cycle after the strobe
    always @(posedge clk_in) begin
        if (rd_pend) begin
            if (exp_q.size() == 0)
                check("unexpected read", 32'h0, 32'h1);
            else
                check("read data", {24'h0, exp_q.pop_front()}, {24'h0, rdata_out});
        end else if (rst_n_in && rdata_out !== 8'h00) begin
            check("idle read data", 32'h0, {24'h0, rdata_out});
        end
        rd_pend <= rd_in && rst_n_in;
    end

    // external input: one rising edge every 4 clocks
    always @(posedge clk_in) begin
        ext_cnt <= ext_cnt + 2'h1;
        ext_clock_in <= ext_en & ext_cnt[1];
    end

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail++;
            $display("CHECK FAILED timeout expected finish seen hang");
            test_done();
        end
    end

    task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= w;
        rd_in <= r;
        addr_in <= a;
        wdata_in <= d;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask

    task automatic idle(input int n);
        bus(1'b0, 1'b0, addr_in, wdata_in);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic wait_pin(input logic level, output int cnt);
        cnt = 0;
        while (timer_output_pin_out !== level && cnt < 20000) begin
            @(posedge clk_in);
            cnt++;
        end
    endtask

    task automatic pwm(input logic [1:0] lclk, input logic [1:0] cyc, input int tick,
                       input bit dbuf);
        int n, cmp, hi, lo, junk;
        n = (cyc == CYCLE_2E6) ? 64 : (cyc == CYCLE_2E7) ? 128 : 256;
        cmp = rnd(n - 1) + 1;
        wr(OFS_RUN, 8'h00);
        wr(OFS_MODE, {2'h3, cyc, 2'h1, lclk});
        wr(OFS_LCMP, cmp[7:0]);
        wr(OFS_FFCR, {4'h0, FF_CTRL_CLEAR, 2'h2});
        wr(OFS_RUN, 8'h87);
        idle(1);
        wait_pin(1'b1, junk);
        wait_pin(1'b0, hi);
        wait_pin(1'b1, lo);
        check("high time", (n - cmp) * tick, hi);
        check("low time", cmp * tick, lo);
        if (dbuf) begin
            cmp = rnd(n - 1) + 1;
            wr(OFS_LCMP, cmp[7:0]);
            idle(1);
            wait_pin(1'b0, junk);
            wait_pin(1'b1, lo);
            wait_pin(1'b0, hi);
            check("buffered low time", cmp * tick, lo);
            check("buffered high time", (n - cmp) * tick, hi);
        end
    endtask

    logic [1:0] ff_code [5] = '{FF_CTRL_CLEAR, FF_CTRL_SET, FF_CTRL_INVERT, FF_CTRL_KEEP,
                                FF_CTRL_INVERT};
    logic ff_exp [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

    initial begin
        int v;
        logic [7:0] b;
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        // reset values, index 7 included
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), (i == int'(OFS_FFCR)) ? 8'h0C : 8'h00);
        end
        wr(3'h7, 8'hFF);
        wr(OFS_LCNT, 8'h55);
        rd(3'h7, 8'h00);
        rd(OFS_LCNT, 8'h00);
        for (int pm = 0; pm < 4; pm++) begin
            v = rnd(64);
            b = {2'(pm), v[5:0]};
            wr(OFS_MODE, b);
            rd(OFS_MODE, b);
        end
        v = rnd(256);
        wr(OFS_UCMP, v[7:0]);
        rd(OFS_UCMP, v[7:0]);
        wr(OFS_LCMP, ~v[7:0]);
        rd(OFS_LCMP, ~v[7:0]);
        wr(OFS_RUN, 8'h80);
        rd(OFS_RUN, 8'h80);
        wr(OFS_RUN, 8'h00);
        wr(OFS_MODE, 8'h00);
        idle(1);
        // flip-flop control codes, timer stopped
        for (int i = 0; i < 5; i++) begin
            wr(OFS_FFCR, {4'h0, ff_code[i], 2'h2});
            idle(1);
            check("flip-flop", {31'h0, ff_exp[i]}, {31'h0, timer_output_pin_out});
        end
        rd(OFS_FFCR, 8'h0E);
        pwm(2'h1, CYCLE_2E6, TAP_FINE_DIV, 1'b1);
        pwm(2'h1, CYCLE_2E7, TAP_FINE_DIV, 1'b1);
        pwm(2'h1, 2'h3, TAP_FINE_DIV, 1'b1);
        pwm(2'h2, CYCLE_2E6, TAP_MEDIUM_DIV, 1'b0);
        pwm(2'h3, CYCLE_2E6, TAP_COARSE_DIV, 1'b0);
        ext_en <= 1'b1;
        pwm(2'h0, CYCLE_2E6, 4, 1'b0);
        // inversion disabled: events must not move the pin
        wr(OFS_RUN, 8'h00);
        wr(OFS_FFCR, {4'h0, FF_CTRL_CLEAR, 2'h0});
        wr(OFS_RUN, 8'h87);
        idle(600);
        check("pin without inversion", 32'h0, {31'h0, timer_output_pin_out});
        // stopping clears the counter and freezes the pin
        wr(OFS_RUN, 8'h84);
        wr(OFS_FFCR, {4'h0, FF_CTRL_SET, 2'h2});
        idle(2);
        rd(OFS_LCNT, 8'h00);
        idle(600);
        rd(OFS_LCNT, 8'h00);
        idle(3);
        check("pin while stopped", 32'h1, {31'h0, timer_output_pin_out});
        // cascade: upper counter holds 1 between the first wrap and the 16-bit match
        wr(OFS_RUN, 8'h00);
        wr(OFS_MODE, 8'h45);
        wr(OFS_UCMP, 8'h01);
        wr(OFS_LCMP, 8'h10);
        wr(OFS_RUN, 8'h07);
        idle(2100);
        rd(OFS_UCNT, 8'h01);
        idle(1);
        test_done();
    end
endmodule // tb_timer_pair_pwm
